// ===== verilog/epv_top.sv
// exception priority and vector selection with apb register file
//
// Function
// R01 - every vector 16-bit, top 128 bytes
// R02 - six highest vectors: resets, non-maskable sources
// R03 - fixed non-maskable order, reset to pin
// R04 - pin request taken only while x mask clear
// R05 - maskable sources need global mask clear
// R06 - global mask set at reset, always writable
// R07 - one maskable source promoted to top
// R08 - promoted source still masked and locally gated
// R09 - promotion never changes a source vector
// R10 - priority register writable only while masked
// R11 - nonmaskable pin level only; irq may be level
// R12 - nothing pending at service gives trap
// R13 - irq edge latched, cleared on service
// R14 - other sources held in flag bits
// R15 - default order F2 down to C2
// R16 - clock monitor FFFC, gated by enables only
// R17 - accumulator edge DA, mask plus enable
// R18 - serial transfer D8, mask plus enable
// R19 - key wake ports share CE, per-pin enable
// R20 - down counter CC, mask plus enable
// R21 - priority register resets to F2
// R22 - bad priority code defaults to irq
// R23 - edge select: zero level, one falling
// R24 - present highest pending vector at boundary
`timescale 1ns/1ps

module epv_top (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output      logic [31:0] prdata_out,
  output      logic        pready_out,
  output      logic        pslverr_out,
  // request pins, active low, asynchronous
  input  wire logic        irq_n_in,
  input  wire logic        nonmaskable_request_pin_n_in,
  // non-maskable requests from reset logic and core
  input  wire logic        reset_req_in,
  input  wire logic        clkmon_fail_in,
  input  wire logic        wdog_reset_in,
  input  wire logic        unimpl_trap_in,
  input  wire logic        software_trap_in,
  // maskable peripheral events, one-cycle pulses
  input  wire logic [24:0] periph_evt_in,
  input  wire logic [14:0] wake_evt_in,
  // core side
  input  wire logic        service_ack_in,
  output      logic [15:0] vector_out,
  output      logic        vector_valid_out
);

  // ==========================================================
  // state
  // one packed record; the comb block fills a copy each cycle
  typedef struct packed {
    logic        i_mask;
    logic        x_mask;
    logic        edge_sel;
    logic        irq_conn;
    logic        clock_monitor_enable;
    logic        forced_monitor_enable;
    logic [7:0]  prio;
    logic [24:0] loc_en;
    logic [14:0] wake_en;
    logic [24:0] flag;
    logic [14:0] wake_flag;
    logic        irq_prev;
    logic        irq_latch;
    logic [15:0] vec;
    logic        vec_valid;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } epv_st_t;

  epv_st_t     st_q;
  epv_st_t     st_d;
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  // filtered, still active-low copies of the two request pins
  logic [1:0]  pin_level;
  logic        irq_lvl_n;
  logic        nm_pin_lvl_n;

  // ==========================================================
  // reset release through two flops
  // assertion stays asynchronous, release is clocked so that no
  // flop leaves reset on a different edge than its neighbours
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // pin synchronisers
  // both request pins come from outside the clock domain; the
  // filtered level lags the pin by four edges
  epv_sync #(
    .W (2)
  ) epv_sync_inst (
    .clk_in    (mclk_in),
    .rst_n_in  (rst_n),
    .pin_in    ({nonmaskable_request_pin_n_in, irq_n_in}),
    .level_out (pin_level)
  );

  assign irq_lvl_n    = pin_level[0];
  assign nm_pin_lvl_n = pin_level[1];

  // ==========================================================
  // promotion code to source index; bad codes fall back to irq
  // odd codes and codes outside the table name no source, so the
  // external request keeps the top slot instead
  function automatic logic [4:0] prio_index(input logic [7:0] code);
    logic [7:0] diff;
    diff = epv_pkg::PRIO_TOP - code;
    if (code > epv_pkg::PRIO_TOP || code < epv_pkg::PRIO_LOW ||
        code[0]) begin
      prio_index = epv_pkg::IDX_IRQ; // R22
    end else begin
      prio_index = diff[5:1]; // R15
    end
  endfunction : prio_index

  // ==========================================================
  // request evaluation, selection and register access
  // one pass per cycle: pending, gating, ordering, then the bus;
  // every result is registered, so the core sees it one edge later
  always_comb begin
    logic [24:0] pend;
    logic [24:0] req;
    logic [4:0]  prom;
    logic [4:0]  sel;
    logic        msk_any;
    logic        nm_any;
    logic [15:0] nm_vec;
    logic        irq_fall;
    logic        acc;
    logic        wr;
    logic        rd_ok;
    logic [31:0] rdat;
    logic        irq_served;
    pend       = '0;
    req        = '0;
    prom       = '0;
    sel        = '0;
    msk_any    = 1'b0;
    nm_any     = 1'b1;
    nm_vec     = epv_pkg::VEC_TRAP;
    irq_fall   = 1'b0;
    acc        = 1'b0;
    wr         = 1'b0;
    rd_ok      = 1'b1;
    rdat       = '0;
    irq_served = 1'b0;
    st_d       = st_q;

    // irq edge detect on the filtered pin, falling edge only
    // prev resets high, so no false edge follows reset
    st_d.irq_prev = irq_lvl_n;
    irq_fall = st_q.irq_prev & ~irq_lvl_n & st_q.irq_conn;
    irq_served = service_ack_in && st_q.vec_valid &&
                 st_q.vec == epv_pkg::VEC_MSK_TOP;

    // latch cleared on service, a fresh edge wins the same cycle
    // edge mode only; level mode keeps the latch empty
    if (st_q.edge_sel && irq_fall) begin
      st_d.irq_latch = 1'b1; // R13
    end else if (irq_served || !st_q.edge_sel) begin
      st_d.irq_latch = 1'b0; // R13
    end

    // pending vector: irq by mode, key wake per pin, rest from flags
    // the wake slot is rebuilt each cycle from its own flags
    pend = st_q.flag; // R14
    if (st_q.edge_sel) begin
      pend[epv_pkg::IDX_IRQ] = st_q.irq_latch; // R23
    end else begin
      pend[epv_pkg::IDX_IRQ] = ~irq_lvl_n; // R11 R23
    end
    pend[epv_pkg::IDX_WAKE] = |(st_q.wake_flag & st_q.wake_en); // R19

    // local enables; irq uses connect bit, wake uses per-pin enables
    // the global mask comes last and also blocks a promoted source
    req = pend & st_q.loc_en; // R17 R18 R20
    req[epv_pkg::IDX_IRQ]  = pend[epv_pkg::IDX_IRQ] & st_q.irq_conn;
    req[epv_pkg::IDX_WAKE] = pend[epv_pkg::IDX_WAKE];
    if (st_q.i_mask) begin
      req = '0; // R05 R08
    end

    // default order: lowest index (highest vector) first
    // loop runs from the bottom so the highest vector is left in sel
    for (int k = epv_pkg::NUM_SRC - 1; k >= 0; k--) begin
      if (req[k]) begin
        sel = 5'(k); // R15
      end
    end
    msk_any = |req;
    // promotion only reorders; the vector still follows the index
    prom = prio_index(st_q.prio);
    if (req[prom]) begin
      sel = prom; // R07
    end

    // fixed non-maskable order
    // clock monitor counts only when one of its enables is set;
    // the pin request is level only and waits for the x mask
    if (reset_req_in) begin
      nm_vec = epv_pkg::VEC_RESET; // R03
    end else if (clkmon_fail_in && (st_q.clock_monitor_enable ||
                 st_q.forced_monitor_enable)) begin
      nm_vec = epv_pkg::VEC_CLKMON; // R16
    end else if (wdog_reset_in) begin
      nm_vec = epv_pkg::VEC_WDOG; // R03
    end else if (unimpl_trap_in) begin
      nm_vec = epv_pkg::VEC_TRAP; // R03
    end else if (software_trap_in) begin
      nm_vec = epv_pkg::VEC_SW_TRAP; // R03
    end else if (!nm_pin_lvl_n && !st_q.x_mask) begin
      nm_vec = epv_pkg::VEC_NM_PIN; // R04 R11
    end else begin
      nm_any = 1'b0;
    end

    // presented vector; trap when nothing remains pending
    // valid low with the trap vector, so a core that services
    // anyway lands in the trap routine
    if (nm_any) begin
      st_d.vec       = nm_vec; // R02 R24
      st_d.vec_valid = 1'b1;
    end else if (msk_any) begin
      st_d.vec       = epv_pkg::msk_vector(sel); // R01 R09
      st_d.vec_valid = 1'b1;
    end else begin
      st_d.vec       = epv_pkg::VEC_TRAP; // R12
      st_d.vec_valid = 1'b0;
    end

    // apb: one wait state, write lands on the completing edge
    // the wait gives the read mux a full cycle; pready drops by
    // itself, so back-to-back transfers see a fresh setup
    acc = psel_in & penable_in;
    st_d.pready = acc & ~st_q.pready;
    wr = acc & st_q.pready & pwrite_in;

    // read decode, also flags unmapped addresses
    // status is read-only; writes to it are quietly dropped
    if (paddr_in == epv_pkg::OFS_CTRL) begin
      rdat = {26'h000_0000, st_q.forced_monitor_enable,
              st_q.clock_monitor_enable, st_q.irq_conn,
              st_q.edge_sel, st_q.x_mask, st_q.i_mask};
    end else if (paddr_in == epv_pkg::OFS_PRIO) begin
      rdat = {24'h00_0000, st_q.prio};
    end else if (paddr_in == epv_pkg::OFS_LOC_EN) begin
      rdat = {7'h00, st_q.loc_en};
    end else if (paddr_in == epv_pkg::OFS_WAKE_EN) begin
      rdat = {17'h0_0000, st_q.wake_en};
    end else if (paddr_in == epv_pkg::OFS_FLAG) begin
      rdat = {7'h00, st_q.flag};
    end else if (paddr_in == epv_pkg::OFS_WAKE_FLAG) begin
      rdat = {17'h0_0000, st_q.wake_flag};
    end else if (paddr_in == epv_pkg::OFS_STATUS) begin
      rdat = '0;
      rdat[epv_pkg::STAT_VALID] = st_q.vec_valid;
      rdat[epv_pkg::STAT_LATCH] = st_q.irq_latch;
      rdat[15:0] = st_q.vec;
    end else begin
      rd_ok = 1'b0;
    end
    st_d.prdata  = (st_d.pready && !pwrite_in) ? rdat : '0;
    st_d.pslverr = st_d.pready & ~rd_ok;

    // register writes
    // the mask bits stay writable at all times
    if (wr && paddr_in == epv_pkg::OFS_CTRL) begin
      st_d.i_mask   = pwdata_in[epv_pkg::CTRL_I_MASK]; // R06
      st_d.x_mask   = pwdata_in[epv_pkg::CTRL_X_MASK];
      st_d.edge_sel = pwdata_in[epv_pkg::CTRL_EDGE_SEL];
      st_d.irq_conn = pwdata_in[epv_pkg::CTRL_IRQ_CONN];
      st_d.clock_monitor_enable  = pwdata_in[epv_pkg::CTRL_CLK_MON_EN];
      st_d.forced_monitor_enable = pwdata_in[epv_pkg::CTRL_FORCED_MON_EN];
    end else if (wr && paddr_in == epv_pkg::OFS_PRIO) begin
      // ignored while interrupts are enabled, to keep order stable
      if (st_q.i_mask) begin
        st_d.prio = pwdata_in[7:0]; // R10
      end
    end else if (wr && paddr_in == epv_pkg::OFS_LOC_EN) begin
      st_d.loc_en = pwdata_in[24:0];
    end else if (wr && paddr_in == epv_pkg::OFS_WAKE_EN) begin
      st_d.wake_en = pwdata_in[14:0];
    end

    // flags: write one to clear, a new event in the same cycle wins
    // bits 0 and 18 never hold a flag: the pin and the wake ports
    // have their own storage
    if (wr && paddr_in == epv_pkg::OFS_FLAG) begin
      st_d.flag = st_q.flag & ~pwdata_in[24:0];
    end
    if (wr && paddr_in == epv_pkg::OFS_WAKE_FLAG) begin
      st_d.wake_flag = st_q.wake_flag & ~pwdata_in[14:0];
    end
    st_d.flag = st_d.flag | periph_evt_in; // R14
    st_d.flag[epv_pkg::IDX_IRQ]  = 1'b0;
    st_d.flag[epv_pkg::IDX_WAKE] = 1'b0;
    st_d.wake_flag = st_d.wake_flag | wake_evt_in; // R19
  end

  // ==========================================================
  // state register; masks set and irq promoted out of reset
  // everything not named here resets to zero: enables, flags, bus
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q           <= '0;
      st_q.i_mask    <= epv_pkg::CTRL_RESET[epv_pkg::CTRL_I_MASK]; // R06
      st_q.x_mask    <= epv_pkg::CTRL_RESET[epv_pkg::CTRL_X_MASK];
      st_q.edge_sel  <= epv_pkg::CTRL_RESET[epv_pkg::CTRL_EDGE_SEL];
      st_q.irq_conn  <= epv_pkg::CTRL_RESET[epv_pkg::CTRL_IRQ_CONN];
      st_q.prio      <= epv_pkg::PRIO_RESET; // R21
      st_q.irq_prev  <= 1'b1;
      st_q.vec       <= epv_pkg::VEC_TRAP;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs straight from flops
  // no logic between the state flops and the pins
  assign prdata_out       = st_q.prdata;
  assign pready_out       = st_q.pready;
  assign pslverr_out      = st_q.pslverr;
  assign vector_out       = st_q.vec;
  assign vector_valid_out = st_q.vec_valid;

endmodule : epv_top

// ===== include/epv_pkg.sv
// package: constants for the exception priority and vectoring block
package epv_pkg;

  // ==========================================================
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PRIO      = 8'h04;
  localparam logic [7:0] OFS_LOC_EN    = 8'h08;
  localparam logic [7:0] OFS_WAKE_EN   = 8'h0C;
  localparam logic [7:0] OFS_FLAG      = 8'h10;
  localparam logic [7:0] OFS_WAKE_FLAG = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;

  // ==========================================================
  // control register field positions
  localparam int CTRL_I_MASK   = 0;
  localparam int CTRL_X_MASK   = 1;
  localparam int CTRL_EDGE_SEL = 2;
  localparam int CTRL_IRQ_CONN = 3;
  localparam int CTRL_CLK_MON_EN    = 4;
  localparam int CTRL_FORCED_MON_EN = 5;
  localparam int STAT_VALID    = 31;
  localparam int STAT_LATCH    = 30;

  // ==========================================================
  // reset values
  localparam logic [5:0] CTRL_RESET = 6'h0B; // i, x masked, irq connected
  localparam logic [7:0] PRIO_RESET = 8'hF2;

  // ==========================================================
  // maskable source table: index k uses vector FFF2 - 2k
  localparam int NUM_SRC  = 25;
  localparam int NUM_WAKE = 15;
  localparam logic [4:0] IDX_IRQ  = 5'd0;
  localparam logic [4:0] IDX_WAKE = 5'd18;
  localparam logic [7:0] PRIO_TOP = 8'hF2;
  localparam logic [7:0] PRIO_LOW = 8'hC2;

  // ==========================================================
  // fixed vectors of the non-maskable sources
  localparam logic [15:0] VEC_RESET  = 16'hFFFE;
  localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
  localparam logic [15:0] VEC_WDOG   = 16'hFFFA;
  localparam logic [15:0] VEC_TRAP   = 16'hFFF8;
  localparam logic [15:0] VEC_SW_TRAP = 16'hFFF6;
  localparam logic [15:0] VEC_NM_PIN  = 16'hFFF4;
  localparam logic [15:0] VEC_MSK_TOP = 16'hFFF2;

  // maskable vector from source index
  function automatic logic [15:0] msk_vector(input logic [4:0] idx);
    msk_vector = VEC_MSK_TOP - {10'h000, idx, 1'b0};
  endfunction : msk_vector

endpackage : epv_pkg

// ===== verilog/epv_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module epv_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // asynchronous pins and filtered copy
  input  wire logic [W-1:0] pin_in,
  output      logic [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } epv_sync_st_t;

  epv_sync_st_t st_q;
  epv_sync_st_t st_d;

  // ==========================================================
  // next state: first stage feeds only the second
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      // a change counts only once stages two and three agree
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.level[i] = st_q.s3[i];
      end
    end
  end

  // ==========================================================
  // pins idle high (active-low requests)
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.level;

endmodule : epv_sync

// ===== verif/epv_core_model.sv
// core model: takes the presented exception after a set delay
`timescale 1ns/1ps

module epv_core_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // bench control
  input  wire logic       take_en_in,
  input  wire logic [3:0] delay_in,
  // core side of the block
  input  wire logic       valid_in,
  output      logic       ack_out
);
  logic [3:0] wait_q;
  // ==========================================================
  // count boundary cycles, then take the exception once;
  // a pause after each ack lets the block drop its vector first
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_q  <= 4'h0;
      ack_out <= 1'b0;
    end else begin
      ack_out <= 1'b0;
      if (!take_en_in || !valid_in || ack_out) begin
        wait_q <= 4'h0;
      end else if (wait_q == delay_in) begin
        ack_out <= 1'b1;
        wait_q  <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : epv_core_model

// ===== verif/epv_top_asserts.sv
// checker: port-level assertions for the exception vector block
`timescale 1ns/1ps

module epv_top_chk (
  // clock and reset
  input wire logic        mclk_in,
  input wire logic        rstn_in,
  // apb slave side
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // non-maskable requests
  input wire logic        reset_req_in,
  input wire logic        clkmon_fail_in,
  input wire logic        wdog_reset_in,
  input wire logic        unimpl_trap_in,
  input wire logic        software_trap_in,
  // core side
  input wire logic [15:0] vector_out,
  input wire logic        vector_valid_out
);
  // ==========================================================
  // settle count: internal reset trails the pin by two edges
  logic [1:0] live_q;
  logic       up;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in)
      live_q <= 2'd0;
    else if (!up)
      live_q <= live_q + 2'd1;
  end
  assign up = (live_q == 2'd3);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // ==========================================================
  // bus handshake
  a_one_wait: assert property ($rose(penable_in) && psel_in |->
    !pready_out ##1 pready_out) else $error("apb wait state wrong");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready_out |-> prdata_out == 0)
    else $error("read data outside ready cycle");
  // ==========================================================
  // vector selection
  a_reset_top: assert property (
    up && reset_req_in |=> vector_valid_out && vector_out == 16'hFFFE)
    else $error("reset request not on top");
  a_wdog_order: assert property (
    up && wdog_reset_in && !reset_req_in && !clkmon_fail_in
    |=> vector_out == 16'hFFFA) else $error("watchdog vector wrong");
  a_swtrap_order: assert property (
    up && software_trap_in && !(reset_req_in || clkmon_fail_in ||
    wdog_reset_in || unimpl_trap_in) |=> vector_out == 16'hFFF6)
    else $error("software trap vector wrong");
  a_clkmon_src: assert property (
    vector_valid_out && vector_out == 16'hFFFC |->
    $past(clkmon_fail_in) && !$past(reset_req_in))
    else $error("clock monitor vector without cause");
  a_vec_window: assert property (
    vector_valid_out |-> vector_out[15:7] == 9'h1FF && !vector_out[0]
    && vector_out >= 16'hFFC2) else $error("vector outside table");
  a_idle_trap: assert property (
    !vector_valid_out |-> vector_out == 16'hFFF8)
    else $error("idle vector not trap");
  c_err: cover property (pready_out && pslverr_out);
  c_irq: cover property (vector_valid_out && vector_out == 16'hFFF2);
  c_wake: cover property (vector_valid_out && vector_out == 16'hFFCE);
endmodule : epv_top_chk

bind epv_top epv_top_chk epv_top_chk_inst (.mclk_in, .rstn_in, .psel_in,
  .penable_in, .prdata_out, .pready_out, .pslverr_out, .reset_req_in,
  .clkmon_fail_in, .wdog_reset_in, .unimpl_trap_in, .software_trap_in,
  .vector_out, .vector_valid_out);

// ===== verif/exception_priority_vectoring_tb_top.sv
// testbench: register, vector and priority checks over apb
`timescale 1ns/1ps

module exception_priority_vectoring_tb_top;
  // ==========================================================
  // connections and scoreboard
  logic        mclk_in, rstn_in, psel_in, penable_in, pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic        pready_out, pslverr_out, irq_n_in;
  logic        nonmaskable_request_pin_n_in;
  logic        service_ack_in, vector_valid_out, take_en;
  logic [4:0]  nmi;
  logic [24:0] periph_evt_in, ev, en, p;
  logic [14:0] wake_evt_in, we, wv;
  logic [15:0] vector_out;
  logic [4:0]  k;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0]  codes[10] = '{8'hDA, 8'hD8, 8'hCC, 8'hCE, 8'hF0, 8'hC2,
                             8'hF4, 8'hD9, 8'hC0, 8'hF2};
  int          error_cnt = 0;
  int          n_checks = 0;
  epv_top epv_top_inst (.mclk_in, .rstn_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .irq_n_in, .nonmaskable_request_pin_n_in,
    .reset_req_in(nmi[4]), .clkmon_fail_in(nmi[3]),
    .wdog_reset_in(nmi[2]), .unimpl_trap_in(nmi[1]),
    .software_trap_in(nmi[0]), .periph_evt_in,
    .wake_evt_in, .service_ack_in, .vector_out, .vector_valid_out);
  epv_core_model epv_core_model_inst (.clk_in(mclk_in),
    .rst_n_in(rstn_in), .take_en_in(take_en), .delay_in(4'h3),
    .valid_in(vector_valid_out), .ack_out(service_ack_in));
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  // ==========================================================
  // bus tasks; a transfer stays up so the next may follow at once
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (pready_out !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
  endtask : apb
  task automatic idle(input int n);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    repeat (n) @(posedge mclk_in);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [32:0] e);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic st(input logic v, input logic [15:0] vec);
    rd(epv_pkg::OFS_STATUS, 32'h8000_FFFF, {1'b0, v, 15'h0000, vec});
  endtask : st
  // expected winner: promoted source first, then lowest index
  function automatic logic [15:0] pick(input logic [24:0] q,
                                       input logic [7:0] c);
    logic [4:0] j;
    j = 5'((8'hF2 - c) >> 1);
    if (c >= 8'hC2 && c <= 8'hF2 && !c[0] && q[j])
      return {8'hFF, c};
    for (int i = 0; i < 25; i++)
      if (q[i])
        return 16'hFFF2 - 16'(2 * i);
    return 16'hFFF8;
  endfunction : pick
  // read results come back in request order
  // status reads also hold the core-side pins against the same note
  always @(posedge mclk_in) begin : mon
    logic [32:0] e;
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in) begin
      e = exp_q.pop_front();
      check({pslverr_out, prdata_out & msk_q.pop_front()}, e);
      if (paddr_in == epv_pkg::OFS_STATUS)
        check({1'b0, vector_valid_out, 15'h0000, vector_out}, e);
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {rstn_in, psel_in, penable_in, pwrite_in, take_en} = 5'h00;
    {paddr_in, pwdata_in, nmi, periph_evt_in, wake_evt_in} = '0;
    {irq_n_in, nonmaskable_request_pin_n_in} = 2'b11;
    void'($urandom(32'h7110));
    repeat (8) @(posedge mclk_in);
    rstn_in <= 1'b1;
    idle(4);
    rd(epv_pkg::OFS_CTRL, 32'h0000_003F, 33'h0_0000_000B);
    rd(epv_pkg::OFS_PRIO, 32'h0000_00FF, 33'h0_0000_00F2);
    rd(8'h1C, 32'hFFFF_FFFF, 33'h1_0000_0000);
    st(1'b0, 16'hFFF8);
    $display("test reset values done");
    foreach (codes[i]) begin
      ev = 25'($urandom());
      en = 25'($urandom());
      we = 15'($urandom()) & 15'h7F7F;
      wv = 15'($urandom()) & 15'h7F7F;
      k = 5'((8'hF2 - codes[i]) >> 1);
      if (codes[i] >= 8'hC2 && codes[i] <= 8'hF2) begin
        ev[k] = 1'b1;
        en[k] = i[0];
      end
      p = ev & en & 25'h1FB_FFFE;
      p[18] = |(we & wv);
      wr(epv_pkg::OFS_CTRL, 32'h0000_000B);
      wr(epv_pkg::OFS_PRIO, {24'h00_0000, codes[i]});
      wr(epv_pkg::OFS_LOC_EN, {7'h00, en});
      wr(epv_pkg::OFS_WAKE_EN, {17'h0_0000, we});
      idle(1);
      periph_evt_in <= ev;
      wake_evt_in <= wv;
      @(posedge mclk_in);
      periph_evt_in <= '0;
      wake_evt_in <= '0;
      rd(epv_pkg::OFS_FLAG, 32'h01FF_FFFF, {8'h00, ev & 25'h1FB_FFFE});
      st(1'b0, 16'hFFF8);
      wr(epv_pkg::OFS_CTRL, 32'h0000_000A);
      idle(3);
      st(|p, pick(p, codes[i]));
      wr(epv_pkg::OFS_FLAG, 32'hFFFF_FFFF);
      wr(epv_pkg::OFS_WAKE_FLAG, 32'h0000_7FFF);
      idle(3);
      st(1'b0, 16'hFFF8);
    end
    wr(epv_pkg::OFS_PRIO, 32'h0000_00D8);
    rd(epv_pkg::OFS_PRIO, 32'h0000_00FF, 33'h0_0000_00F2);
    $display("test maskable priority done");
    wr(epv_pkg::OFS_CTRL, 32'h0000_0019);
    nonmaskable_request_pin_n_in <= 1'b0;
    for (int j = 0; j < 6; j++) begin
      nmi <= 5'h1F >> j;
      idle(6);
      st(1'b1, 16'hFFFE - 16'(2 * j));
    end
    wr(epv_pkg::OFS_CTRL, 32'h0000_000B);
    idle(6);
    st(1'b0, 16'hFFF8);
    nmi <= 5'h08;
    idle(4);
    st(1'b0, 16'hFFF8);
    wr(epv_pkg::OFS_CTRL, 32'h0000_002B);
    idle(4);
    st(1'b1, 16'hFFFC);
    nmi <= 5'h00;
    nonmaskable_request_pin_n_in <= 1'b1;
    $display("test non-maskable order done");
    wr(epv_pkg::OFS_CTRL, 32'h0000_000E);
    irq_n_in <= 1'b0;
    idle(8);
    irq_n_in <= 1'b1;
    idle(8);
    st(1'b1, 16'hFFF2);
    take_en <= 1'b1;
    idle(12);
    st(1'b0, 16'hFFF8);
    take_en <= 1'b0;
    wr(epv_pkg::OFS_CTRL, 32'h0000_000A);
    irq_n_in <= 1'b0;
    idle(8);
    st(1'b1, 16'hFFF2);
    irq_n_in <= 1'b1;
    idle(8);
    st(1'b0, 16'hFFF8);
    $display("test pin sensing done");
    idle(4);
    end_of_test();
  end
endmodule : exception_priority_vectoring_tb_top
